// >>> src/rbr_pkg.sv
// package: command codes, field layouts and constants for the head command interpreter
package rbr_pkg;

    // ****************************************
    // command and response codes
    // ****************************************
    localparam logic [15:0] CMD_IDLE    = 16'h0000;
    localparam logic [15:0] CMD_RESTORE = 16'h1000;
    localparam logic [15:0] CMD_BACKUP  = 16'h1001;
    localparam logic [15:0] CMD_RESET   = 16'h8000;

    // ****************************************
    // reset kinds and error codes
    // ****************************************
    localparam logic [15:0] RST_KIND_SOFT   = 16'h0000;
    localparam logic [15:0] RST_KIND_SUPPLY = 16'h0001;
    localparam logic [15:0] ERR_NONE        = 16'h0000;
    localparam logic [15:0] ERR_NOT_UHF     = 16'h0001;
    localparam logic [15:0] ERR_FRAGMENT    = 16'h0002;
    localparam logic [15:0] ERR_NO_BACKUP   = 16'h0003;
    localparam logic [15:0] ERR_BAD_KIND    = 16'h0004;
    localparam logic [15:0] ERR_HEAD        = 16'h0005;
    localparam logic [15:0] ERR_UNKNOWN     = 16'h0006;

    // ****************************************
    // reset values and cycle counts
    // ****************************************
    localparam logic [7:0]  FRAG_ZERO       = 8'h00;
    localparam int          CLK_MHZ         = 100;
    localparam int          CLR_TIME_NS     = 100;
    localparam int          CLR_CYCLES      = (CLR_TIME_NS * CLK_MHZ + 999) / 1000;

    // request as written by the controller into the process output image
    typedef struct packed {
        logic [7:0]  loop_cnt;
        logic [15:0] cmd;
        logic [7:0]  head_addr;
        logic [15:0] start_addr;
        logic [7:0]  wr_frag;
        logic [7:0]  rd_frag;
    } rbr_req_t;

    // response placed into the process input image
    typedef struct packed {
        logic [7:0]  loop_cnt;
        logic [15:0] resp;
        logic [15:0] err;
        logic [7:0]  wr_frag;
        logic [7:0]  rd_frag;
    } rbr_resp_t;

    // operation towards the head side
    typedef enum logic [2:0] {
        HOP_NONE,
        HOP_READ_CFG,
        HOP_WRITE_CFG,
        HOP_SOFT_RESET,
        HOP_SUPPLY_RESET
    } rbr_hop_t;

endpackage

// >>> src/rbr_core.sv
// module: backup, restore and reset command interpreter for an rfid interface
// Function
// - backup/restore only allowed with UHF head
// - 0x1000 writes stored settings into head
// - 0x1001 reads head settings into storage
// - stored settings kept in non-volatile memory
// - 0x8000 resets head and interface
// - reset clears input, output image, buffer
// - completion echoes command into response code
`timescale 1ns/1ns
`default_nettype none
module rbr_core #(
    parameter int CFG_W = 32
) (
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RSTN,
    // controller request from process output image
    input  wire rbr_pkg::rbr_req_t    REQ,
    // process input image
    output rbr_pkg::rbr_resp_t        RESP,
    // head status and configuration path
    input  wire logic                 HEAD_IS_UHF,
    output var  rbr_pkg::rbr_hop_t    HEAD_OP,
    output logic [CFG_W-1:0]          HEAD_WDATA,
    input  wire logic                 HEAD_DONE,
    input  wire logic                 HEAD_FAIL,
    input  wire logic [CFG_W-1:0]     HEAD_RDATA,
    // non-volatile backup store
    output logic                      NV_WE,
    output logic [CFG_W-1:0]          NV_WDATA,
    input  wire logic [CFG_W-1:0]     NV_RDATA,
    input  wire logic                 NV_VALID,
    // clear strobes for images and buffer
    output logic                      CLR_IMAGES,
    output logic                      CLR_BUFFER
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_CLEAR, ST_DONE} rbr_st_t;

    rbr_st_t           state;
    logic [15:0]       cur_cmd;
    logic [15:0]       last_cmd;
    logic [7:0]        cur_loop;
    logic [7:0]        clr_cnt;
    logic              head_pass;
    logic [15:0]       next_err;
    logic [15:0]       cur_err;

    // a new command is a change of command word away from the last handled one
    wire new_cmd = (state == ST_IDLE) && (REQ.cmd != last_cmd) && (REQ.cmd != rbr_pkg::CMD_IDLE);

    // ****************************************
    // request check
    // ****************************************
    always_comb begin
        next_err = rbr_pkg::ERR_NONE;
        if (REQ.wr_frag != rbr_pkg::FRAG_ZERO) begin
            next_err = rbr_pkg::ERR_FRAGMENT;
        end else if (REQ.cmd == rbr_pkg::CMD_RESTORE || REQ.cmd == rbr_pkg::CMD_BACKUP) begin
            if (!HEAD_IS_UHF) begin
                next_err = rbr_pkg::ERR_NOT_UHF;
            end else if (REQ.cmd == rbr_pkg::CMD_RESTORE && !NV_VALID) begin
                next_err = rbr_pkg::ERR_NO_BACKUP;
            end
        end else if (REQ.cmd == rbr_pkg::CMD_RESET) begin
            if (REQ.start_addr != rbr_pkg::RST_KIND_SOFT &&
                REQ.start_addr != rbr_pkg::RST_KIND_SUPPLY) begin
                next_err = rbr_pkg::ERR_BAD_KIND;
            end
        end else begin
            next_err = rbr_pkg::ERR_UNKNOWN;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state    <= ST_IDLE;
            cur_cmd  <= rbr_pkg::CMD_IDLE;
            last_cmd <= rbr_pkg::CMD_IDLE;
            cur_loop <= 8'h00;
            clr_cnt  <= 8'h00;
            cur_err  <= rbr_pkg::ERR_NONE;
            HEAD_OP  <= rbr_pkg::HOP_NONE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (REQ.cmd == rbr_pkg::CMD_IDLE) begin
                        last_cmd <= rbr_pkg::CMD_IDLE;
                    end
                    if (new_cmd) begin
                        cur_cmd  <= REQ.cmd;
                        cur_loop <= REQ.loop_cnt;
                        cur_err  <= next_err;
                        last_cmd <= REQ.cmd;
                        if (next_err != rbr_pkg::ERR_NONE) begin
                            state <= ST_DONE;
                        end else begin
                            state <= ST_HEAD;
                            unique case (REQ.cmd)
                                rbr_pkg::CMD_RESTORE: HEAD_OP <= rbr_pkg::HOP_WRITE_CFG;
                                rbr_pkg::CMD_BACKUP:  HEAD_OP <= rbr_pkg::HOP_READ_CFG;
                                default: begin
                                    if (REQ.start_addr == rbr_pkg::RST_KIND_SUPPLY) begin
                                        HEAD_OP <= rbr_pkg::HOP_SUPPLY_RESET;
                                    end else begin
                                        HEAD_OP <= rbr_pkg::HOP_SOFT_RESET;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_HEAD: begin
                    if (HEAD_DONE || HEAD_FAIL) begin
                        HEAD_OP <= rbr_pkg::HOP_NONE;
                        if (cur_cmd == rbr_pkg::CMD_RESET) begin
                            state   <= ST_CLEAR;
                            clr_cnt <= 8'(rbr_pkg::CLR_CYCLES);
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_CLEAR: begin
                    clr_cnt <= clr_cnt - 8'h01;
                    if (clr_cnt == 8'h01) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // head result latch
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            head_pass <= 1'b0;
        end else if (new_cmd) begin
            head_pass <= 1'b0;
        end else if (state == ST_HEAD && HEAD_DONE && !HEAD_FAIL) begin
            head_pass <= 1'b1;
        end
    end

    // ****************************************
    // data paths
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            HEAD_WDATA <= '0;
            NV_WE      <= 1'b0;
            NV_WDATA   <= '0;
        end else begin
            NV_WE <= 1'b0;
            if (new_cmd && REQ.cmd == rbr_pkg::CMD_RESTORE) begin
                HEAD_WDATA <= NV_RDATA;
            end
            if (state == ST_HEAD && HEAD_DONE && !HEAD_FAIL && cur_cmd == rbr_pkg::CMD_BACKUP) begin
                NV_WE    <= 1'b1;
                NV_WDATA <= HEAD_RDATA;
            end
        end
    end

    // clear strobes held while clearing
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            CLR_IMAGES <= 1'b0;
            CLR_BUFFER <= 1'b0;
        end else begin
            CLR_IMAGES <= (state == ST_HEAD && cur_cmd == rbr_pkg::CMD_RESET &&
                           (HEAD_DONE || HEAD_FAIL)) ||
                          (state == ST_CLEAR && clr_cnt != 8'h01);
            CLR_BUFFER <= (state == ST_HEAD && cur_cmd == rbr_pkg::CMD_RESET &&
                           (HEAD_DONE || HEAD_FAIL)) ||
                          (state == ST_CLEAR && clr_cnt != 8'h01);
        end
    end

    // ****************************************
    // response image
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RESP <= '0;
        end else if (new_cmd) begin
            RESP <= '0;
        end else if (state == ST_CLEAR) begin
            RESP <= '0;
        end else if (state == ST_DONE) begin
            RESP.loop_cnt <= cur_loop;
            RESP.wr_frag  <= rbr_pkg::FRAG_ZERO;
            RESP.rd_frag  <= rbr_pkg::FRAG_ZERO;
            RESP.resp     <= cur_cmd;
            if (cur_err != rbr_pkg::ERR_NONE) begin
                RESP.err <= cur_err;
            end else if (head_pass) begin
                RESP.err <= rbr_pkg::ERR_NONE;
            end else begin
                // failed head op never looks successful
                RESP.err <= rbr_pkg::ERR_HEAD;
            end
        end
    end

endmodule
`default_nettype wire

// >>> sim/rbr_core_monitor.sv
// checker: port-level properties of the command interpreter
`timescale 1ns/1ns
`default_nettype none
module rbr_core_monitor #(parameter int CFG_W = 32) (
    // watched ports
    input wire logic               CLK,
    input wire logic               RSTN,
    input wire rbr_pkg::rbr_req_t  REQ,
    input wire rbr_pkg::rbr_resp_t RESP,
    input wire logic               HEAD_IS_UHF,
    input wire rbr_pkg::rbr_hop_t  HEAD_OP,
    input wire logic [CFG_W-1:0]   HEAD_WDATA,
    input wire logic               HEAD_DONE,
    input wire logic               HEAD_FAIL,
    input wire logic [CFG_W-1:0]   HEAD_RDATA,
    input wire logic               NV_WE,
    input wire logic [CFG_W-1:0]   NV_WDATA,
    input wire logic [CFG_W-1:0]   NV_RDATA,
    input wire logic               NV_VALID,
    input wire logic               CLR_IMAGES,
    input wire logic               CLR_BUFFER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // length of the current clear burst
    logic [7:0] clr_len;
    always_ff @(posedge CLK) begin
        if (!RSTN || !CLR_IMAGES) begin
            clr_len <= 8'h00;
        end else begin
            clr_len <= clr_len + 8'h01;
        end
    end
    uhf_gate_a: assert property (
        HEAD_OP inside {rbr_pkg::HOP_READ_CFG, rbr_pkg::HOP_WRITE_CFG}
        && $past(HEAD_OP) == rbr_pkg::HOP_NONE |-> $past(HEAD_IS_UHF)) else $error("cfg op on hf");
    nv_source_a: assert property (NV_WE |-> $past(HEAD_OP) == rbr_pkg::HOP_READ_CFG)
        else $error("store write without read");
    nv_pulse_a: assert property (NV_WE |=> !NV_WE) else $error("store write too long");
    backup_echo_a: assert property (NV_WE |=> RESP.resp == rbr_pkg::CMD_BACKUP
        && RESP.err == rbr_pkg::ERR_NONE) else $error("backup not echoed");
    clr_pair_a: assert property (CLR_IMAGES == CLR_BUFFER)
        else $error("clear strobes differ");
    clr_len_a: assert property ($fell(CLR_IMAGES) |-> clr_len == 8'(rbr_pkg::CLR_CYCLES))
        else $error("clear burst length wrong");
    clr_cause_a: assert property ($rose(CLR_IMAGES) |-> $past(HEAD_OP) inside
        {rbr_pkg::HOP_SOFT_RESET, rbr_pkg::HOP_SUPPLY_RESET}) else $error("clear w/o reset");
    reset_echo_a: assert property ($fell(CLR_IMAGES) |=> RESP.resp == rbr_pkg::CMD_RESET)
        else $error("reset not echoed");
    frag_zero_a: assert property (RESP.wr_frag == rbr_pkg::FRAG_ZERO)
        else $error("write fragment not zero");
    restore_data_a: assert property (
        HEAD_OP == rbr_pkg::HOP_WRITE_CFG |-> HEAD_WDATA == NV_RDATA)
        else $error("restore data wrong");
    cover property (NV_WE);
    cover property (CLR_IMAGES);
    cover property (HEAD_OP == rbr_pkg::HOP_WRITE_CFG);
endmodule
bind rbr_core rbr_core_monitor #(.CFG_W(CFG_W)) u_mon (.CLK(CLK), .RSTN(RSTN), .REQ(REQ),
    .RESP(RESP), .HEAD_IS_UHF(HEAD_IS_UHF), .HEAD_OP(HEAD_OP), .HEAD_WDATA(HEAD_WDATA),
    .HEAD_DONE(HEAD_DONE), .HEAD_FAIL(HEAD_FAIL), .HEAD_RDATA(HEAD_RDATA), .NV_WE(NV_WE),
    .NV_WDATA(NV_WDATA), .NV_RDATA(NV_RDATA), .NV_VALID(NV_VALID),
    .CLR_IMAGES(CLR_IMAGES), .CLR_BUFFER(CLR_BUFFER));
`default_nettype wire

// >>> sim/rbr_head_model.sv
// model: head reader and non-volatile backup store
`timescale 1ns/1ns
`default_nettype none
module rbr_head_model #(
    parameter int               CFG_W = 32,
    parameter int               DELAY = 3,
    parameter logic [CFG_W-1:0] PAT   = '1
) (
    // clock, head side, store side
    input  wire logic              CLK,
    input  wire logic              RSTN,
    input  wire logic              FAIL_EN,
    input  wire rbr_pkg::rbr_hop_t HEAD_OP,
    output logic                   HEAD_DONE,
    output logic                   HEAD_FAIL,
    output logic [CFG_W-1:0]       HEAD_RDATA,
    input  wire logic              NV_WE,
    input  wire logic [CFG_W-1:0]  NV_WDATA,
    output logic [CFG_W-1:0]       NV_RDATA,
    output logic                   NV_VALID
);
    int               cnt;
    logic             valid = 1'b0;
    logic [CFG_W-1:0] store = '0;
    always_ff @(posedge CLK) begin
        if (!RSTN || HEAD_OP == rbr_pkg::HOP_NONE) cnt <= 0;
        else cnt <= cnt + 1;
    end
    assign HEAD_DONE  = (cnt == DELAY) && !FAIL_EN;
    assign HEAD_FAIL  = (cnt == DELAY) && FAIL_EN;
    // data only valid with done, inverted otherwise
    assign HEAD_RDATA = HEAD_DONE ? PAT : ~PAT;
    // store survives reset
    always_ff @(posedge CLK) begin
        if (NV_WE) begin
            store <= NV_WDATA;
            valid <= 1'b1;
        end
    end
    assign NV_RDATA = store;
    assign NV_VALID = valid;
endmodule
`default_nettype wire

// >>> sim/rbr_core_test.sv
// testbench: command sequences against the interpreter and head model
`timescale 1ns/1ns
`default_nettype none
module rbr_core_test;
    localparam logic [31:0] PAT = 32'hC3A5_5A3C;
    logic               CLK = 1'b0;
    logic               RSTN = 1'b0;
    logic               uhf = 1'b0;
    logic               fail_en = 1'b0;
    rbr_pkg::rbr_req_t  req = '0;
    rbr_pkg::rbr_resp_t resp;
    rbr_pkg::rbr_hop_t  hop;
    logic               done, hfail, nv_we, nv_valid, clr_i, clr_b;
    logic [31:0]        wdata, rdata, nv_wdata, nv_rdata;
    int                 fail_count = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;
    always #5 CLK = ~CLK;
    rbr_core #(.CFG_W(32)) dut (.CLK(CLK), .RSTN(RSTN), .REQ(req), .RESP(resp),
        .HEAD_IS_UHF(uhf), .HEAD_OP(hop), .HEAD_WDATA(wdata), .HEAD_DONE(done),
        .HEAD_FAIL(hfail), .HEAD_RDATA(rdata), .NV_WE(nv_we), .NV_WDATA(nv_wdata),
        .NV_RDATA(nv_rdata), .NV_VALID(nv_valid), .CLR_IMAGES(clr_i), .CLR_BUFFER(clr_b));
    rbr_head_model #(.CFG_W(32), .PAT(PAT)) head (.CLK(CLK), .RSTN(RSTN), .FAIL_EN(fail_en),
        .HEAD_OP(hop), .HEAD_DONE(done), .HEAD_FAIL(hfail), .HEAD_RDATA(rdata), .NV_WE(nv_we),
        .NV_WDATA(nv_wdata), .NV_RDATA(nv_rdata), .NV_VALID(nv_valid));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic run(input logic [15:0] c, input logic [15:0] sa, input logic [7:0] fr,
                       input logic [15:0] err, input rbr_pkg::rbr_hop_t op);
        rbr_pkg::rbr_hop_t seen;
        logic              clr;
        seen = rbr_pkg::HOP_NONE;
        clr = 1'b0;
        req.loop_cnt = req.loop_cnt + 8'h01;
        req.cmd = c;
        req.start_addr = sa;
        req.wr_frag = fr;
        @(negedge CLK);
        for (int i = 0; i < 40 && resp.resp !== c; i++) begin
            @(negedge CLK);
            if (hop != rbr_pkg::HOP_NONE) seen = hop;
            clr = clr | (clr_i & clr_b);
        end
        check(32'(resp.resp), 32'(c));
        check(32'(resp.err), 32'(err));
        check(32'(resp.wr_frag), 32'h0);
        check(32'(resp.rd_frag), 32'h0);
        check(32'(resp.loop_cnt), 32'(req.loop_cnt));
        check(32'(seen), 32'(op));
        if (err == rbr_pkg::ERR_NONE) check(32'(clr), 32'(c == rbr_pkg::CMD_RESET));
        req.cmd = rbr_pkg::CMD_IDLE;
        repeat (2) @(negedge CLK);
    endtask
    task automatic t_no_uhf();
        uhf = 1'b0;
        run(rbr_pkg::CMD_BACKUP, 0, 0, rbr_pkg::ERR_NOT_UHF, rbr_pkg::HOP_NONE);
        run(rbr_pkg::CMD_RESTORE, 0, 0, rbr_pkg::ERR_NOT_UHF, rbr_pkg::HOP_NONE);
        uhf = 1'b1;
    endtask
    task automatic t_no_backup();
        run(rbr_pkg::CMD_RESTORE, 0, 0, rbr_pkg::ERR_NO_BACKUP, rbr_pkg::HOP_NONE);
    endtask
    task automatic t_backup();
        run(rbr_pkg::CMD_BACKUP, 16'h0005, 0, rbr_pkg::ERR_NONE, rbr_pkg::HOP_READ_CFG);
        check(nv_rdata, PAT);
    endtask
    task automatic t_restore();
        RSTN = 1'b0;
        repeat (3) @(negedge CLK);
        RSTN = 1'b1;
        run(rbr_pkg::CMD_RESTORE, 0, 0, rbr_pkg::ERR_NONE, rbr_pkg::HOP_WRITE_CFG);
        check(wdata, PAT);
    endtask
    task automatic t_reset();
        run(rbr_pkg::CMD_RESET, 0, 0, rbr_pkg::ERR_NONE, rbr_pkg::HOP_SOFT_RESET);
        run(rbr_pkg::CMD_RESET, 1, 0, rbr_pkg::ERR_NONE, rbr_pkg::HOP_SUPPLY_RESET);
        run(rbr_pkg::CMD_RESET, 2, 0, rbr_pkg::ERR_BAD_KIND, rbr_pkg::HOP_NONE);
    endtask
    task automatic t_refuse();
        run(rbr_pkg::CMD_BACKUP, 0, 8'h01, rbr_pkg::ERR_FRAGMENT, rbr_pkg::HOP_NONE);
        run(16'h1234, 0, 0, rbr_pkg::ERR_UNKNOWN, rbr_pkg::HOP_NONE);
        fail_en = 1'b1;
        run(rbr_pkg::CMD_RESET, 0, 0, rbr_pkg::ERR_HEAD, rbr_pkg::HOP_SOFT_RESET);
        fail_en = 1'b0;
    endtask
    initial begin
        repeat (16) @(negedge CLK);
        RSTN = 1'b1;
        t_no_uhf();
        t_no_backup();
        t_backup();
        t_restore();
        t_reset();
        t_refuse();
        final_report();
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 3000) begin
            fail_count++;
            final_report();
        end
    end
endmodule
`default_nettype wire
